/* File: testbench/ast_rx_model.sv */
// remote receiver model that decodes frames from the serial line
`timescale 1ns/100ps
module ast_rx_model (
    // clock and line
    input wire logic core_clk_in,
    input wire logic line_in,
    // frame format
    input wire logic [15:0] bit_clks_in,
    input wire logic nine_in,
    // decoded frame
    output logic [8:0] data_out,
    output logic [7:0] count_out
);
    initial begin
        data_out = 9'h000;
        count_out = 8'h00;
        forever begin
            @(negedge line_in);
            // sample each bit near its middle
            repeat (bit_clks_in / 2) @(posedge core_clk_in);
            data_out = 9'h000;
            for (int k = 0; k < (nine_in ? 9 : 8); k++) begin
                repeat (bit_clks_in) @(posedge core_clk_in);
                data_out[k] = line_in;
            end
            repeat (bit_clks_in) @(posedge core_clk_in);
            // only a frame closed by a high stop bit is counted
            if (line_in === 1'b1) count_out = count_out + 8'h01;
        end
    end
endmodule

/* File: testbench/ast_top_bench.sv */
// self-checking bench for the asynchronous serial transmitter
`timescale 1ns/100ps
`include "ast_defs.svh"
module ast_top_bench;
    import ast_pkg::*;
    typedef struct packed {
        logic wr;
        logic [11:0] a;
        logic [7:0] d;
        logic err;
    } ast_row_s;
    logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [11:0] pa = 12'h000;
    logic [31:0] pwd = 32'h00000000;
    logic sleep = 1'b0, nine = 1'b0;
    logic [15:0] bclk = 16'h0020;
    logic [31:0] prd, q;
    logic prdy, perr, tx, irq, e;
    logic [8:0] rxd;
    logic [7:0] rxn;
    int fails = 0;
    int n_checks = 0;
    int i, m;
    ast_row_s rows [20];
    ast_top ast_top_i (
        .core_clk_in(clk), .resetn_in(rstn),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
        .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd),
        .pready_out(prdy), .pslverr_out(perr),
        .sleep_in(sleep), .tx_out(tx), .tx_irq_out(irq)
    );
    ast_rx_model ast_rx_model_i (
        .core_clk_in(clk), .line_in(tx), .bit_clks_in(bclk),
        .nine_in(nine), .data_out(rxd), .count_out(rxn)
    );
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] s, input logic [31:0] x);
        n_checks++;
        if (s !== x) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, s, x);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [7:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= {24'h000000, d};
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (prdy !== 1'b1 && n < 16);
        if (n >= 16) begin
            fails++;
            end_of_test();
        end
        q = prd;
        e = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] x);
        apb(1'b0, a, 8'h00);
        check(q, {24'h000000, x});
    endtask
    task automatic wait_rx(input logic [7:0] c);
        int n;
        n = 0;
        while (rxn !== c && n < 9000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 9000) begin
            fails++;
            end_of_test();
        end
    endtask
    // length of the next low stretch on the line, in clocks
    task automatic low_run(output int c);
        int n;
        n = 0;
        c = 0;
        while (tx !== 1'b0 && n < 200) begin
            @(negedge clk);
            n++;
        end
        while (tx === 1'b0 && c < 2000) begin
            @(negedge clk);
            c++;
        end
        if (n >= 200 || c >= 2000) begin
            fails++;
            end_of_test();
        end
    endtask
    initial begin
        forever #12.5 clk = ~clk;
    end
    initial begin
        rows = '{
            '{1'b0, `AST_OFF_TSC, 8'h02, 1'b0},
            '{1'b0, `AST_OFF_FLAGS, 8'h00, 1'b0},
            '{1'b0, `AST_OFF_BAUD, 8'h00, 1'b0},
            '{1'b0, `AST_OFF_ENAB, 8'h00, 1'b0},
            '{1'b0, `AST_OFF_TBUF, 8'h00, 1'b0},
            '{1'b0, `AST_OFF_RSC, 8'h00, 1'b0},
            '{1'b0, 12'h018, 8'h00, 1'b1}, '{1'b1, 12'h018, 8'h55, 1'b1},
            '{1'b1, `AST_OFF_FLAGS, 8'h10, 1'b0},
            '{1'b0, `AST_OFF_FLAGS, 8'h00, 1'b0},
            '{1'b1, `AST_OFF_BAUD, 8'hFF, 1'b0},
            '{1'b0, `AST_OFF_BAUD, 8'hFF, 1'b0},
            '{1'b1, `AST_OFF_BAUD, 8'h01, 1'b0},
            '{1'b1, `AST_OFF_RSC, 8'h80, 1'b0},
            '{1'b0, `AST_OFF_RSC, 8'h80, 1'b0},
            '{1'b1, `AST_OFF_ENAB, 8'h10, 1'b0},
            '{1'b0, `AST_OFF_ENAB, 8'h10, 1'b0},
            '{1'b1, `AST_OFF_TSC, 8'h24, 1'b0},
            '{1'b0, `AST_OFF_TSC, 8'h26, 1'b0},
            '{1'b0, `AST_OFF_FLAGS, 8'h10, 1'b0}};
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        for (i = 0; i < 20; i++) begin
            apb(rows[i].wr, rows[i].a, rows[i].d);
            check({31'h0, e}, {31'h0, rows[i].err});
            if (!rows[i].wr) check(q, {24'h0, rows[i].d});
        end
        check({31'h0, irq}, 32'h1);
        apb(1'b1, `AST_OFF_ENAB, 8'h00);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        rd(`AST_OFF_FLAGS, 8'h10);
        $display("test registers done");
        apb(1'b1, `AST_OFF_TBUF, 8'hA5);
        low_run(m);
        check(m, 32'h20);
        apb(1'b1, `AST_OFF_TBUF, 8'h3C);
        rd(`AST_OFF_FLAGS, 8'h00);
        rd(`AST_OFF_TSC, 8'h24);
        wait_rx(8'h01);
        check({23'h0, rxd}, 32'hA5);
        wait_rx(8'h02);
        check({23'h0, rxd}, 32'h3C);
        repeat (40) @(posedge clk);
        rd(`AST_OFF_TSC, 8'h26);
        rd(`AST_OFF_FLAGS, 8'h10);
        $display("test frames done");
        sleep <= 1'b1;
        apb(1'b1, `AST_OFF_TBUF, 8'h5A);
        repeat (100) @(posedge clk);
        check({31'h0, tx}, 32'h1);
        apb(1'b1, `AST_OFF_TSC, 8'h34);
        sleep <= 1'b0;
        repeat (100) @(posedge clk);
        check({31'h0, tx}, 32'h1);
        apb(1'b1, `AST_OFF_TSC, 8'h24);
        wait_rx(8'h03);
        check({23'h0, rxd}, 32'h5A);
        $display("test sleep and mode done");
        apb(1'b1, `AST_OFF_BAUD, 8'h00);
        apb(1'b1, `AST_OFF_TSC, 8'h61);
        bclk <= 16'h0040;
        nine <= 1'b1;
        apb(1'b1, `AST_OFF_TBUF, 8'h00);
        low_run(m);
        check(m, 32'h240);
        wait_rx(8'h04);
        check({23'h0, rxd}, 32'h100);
        $display("test nine bit done");
        apb(1'b1, `AST_OFF_TBUF, 8'hFE);
        repeat (80) @(posedge clk);
        sleep <= 1'b1;
        repeat (100) @(posedge clk);
        check({31'h0, tx}, 32'h0);
        rd(`AST_OFF_TSC, 8'h61);
        apb(1'b1, `AST_OFF_RSC, 8'h00);
        repeat (2) @(posedge clk);
        check({31'h0, tx}, 32'h1);
        rd(`AST_OFF_TSC, 8'h63);
        sleep <= 1'b0;
        $display("test sleep in frame done");
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rd(`AST_OFF_TSC, 8'h02);
        rd(`AST_OFF_FLAGS, 8'h00);
        check({31'h0, tx}, 32'h1);
        $display("test reset done");
        end_of_test();
    end
endmodule

/* File: verilog/ast_defs.svh */
// register offsets, field positions, reset values and counts
`ifndef AST_DEFS_SVH
`define AST_DEFS_SVH
`define AST_OFF_TSC 12'h000
`define AST_OFF_RSC 12'h004
`define AST_OFF_TBUF 12'h008
`define AST_OFF_BAUD 12'h00C
`define AST_OFF_FLAGS 12'h010
`define AST_OFF_ENAB 12'h014
`define AST_B_TRANSMIT_NINTH_BIT 0
`define AST_B_SHIFT_EMPTY_STATUS 1
`define AST_B_HIGH_SPEED_SELECT 2
`define AST_B_SYNC 4
`define AST_B_TRANSMIT_ENABLE_BIT 5
`define AST_B_TX9 6
`define AST_B_SERIAL_PORT_ENABLE 7
`define AST_B_BUFFER_EMPTY_FLAG 4
`define AST_RST_REG 8'h00
`define AST_OS_LO 6'h3F
`define AST_OS_HI 6'h0F
`define AST_NB8 4'h7
`define AST_NB9 4'h8
`endif

/* File: verilog/ast_pkg.sv */
// types shared by the asynchronous serial transmitter
package ast_pkg;
    typedef enum logic [4:0] {
        AST_IDLE = 5'h01,
        AST_LOAD = 5'h02,
        AST_START = 5'h04,
        AST_DATA = 5'h08,
        AST_STOP = 5'h10
    } ast_state_e;
    typedef struct packed {
        logic tx9;
        logic transmit_enable_bit;
        logic sync;
        logic high_speed_select;
        logic transmit_ninth_bit;
    } ast_cfg_s;
endpackage

/* File: verilog/ast_top.sv */
// asynchronous serial transmitter with baud generator and apb registers
// Overview of operation
// - frame: start, eight or nine data, stop
// - data bits leave least significant first
// - eight-bit baud generator from oscillator
// - high speed select picks x16 or x64
// - transmitter independent, shares format and baud
// - no hardware parity; ninth bit carries it
// - sleep halts all serial operation
// - asynchronous mode while clocked mode bit zero
// - shift register reloads only after stop bit
// - one-cycle transfer sets buffer-empty flag
// - irq gated by enable, flag set regardless
// - flag ignores software clear; write clears
// - shift-empty status bit, read only, polled
// - shift register has no address
// - setting transmit enable sets buffer-empty flag
// - ninth bit field sent as ninth data bit
// - buffer write starts frame at idle shifter
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/100ps
`include "ast_defs.svh"
module ast_top (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic resetn_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // power state
    input wire logic sleep_in,
    // serial line and request
    output logic tx_out,
    output logic tx_irq_out
);
    import ast_pkg::*;

    ast_cfg_s cfg_q;
    logic serial_port_enable_q;
    logic [7:0] baud_q;
    logic [7:0] enab_q;
    logic [7:0] tbuf_q;
    logic tbuf_full_q;
    logic flag_q;
    ast_state_e state_q;
    logic [8:0] shift_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] brg_cnt_q;
    logic [5:0] os_cnt_q;
    logic bit_tick;
    logic run;
    logic wr_en;
    logic setup;
    logic mapped;
    logic [7:0] rd_byte;
    logic xfer;
    logic wr_tbuf;
    logic transmit_enable_bit_rise;

    // apb decode
    assign setup = psel_in && !penable_in && !pready_out;
    assign wr_en = psel_in && penable_in && pready_out && pwrite_in;
    assign wr_tbuf = wr_en && (paddr_in == `AST_OFF_TBUF);

    always_comb begin
        mapped = 1'b1;
        rd_byte = `AST_RST_REG;
        case (paddr_in)
            `AST_OFF_TSC: begin
                rd_byte[`AST_B_TX9] = cfg_q.tx9;
                rd_byte[`AST_B_TRANSMIT_ENABLE_BIT] = cfg_q.transmit_enable_bit;
                rd_byte[`AST_B_SYNC] = cfg_q.sync;
                rd_byte[`AST_B_HIGH_SPEED_SELECT] = cfg_q.high_speed_select;
                rd_byte[`AST_B_SHIFT_EMPTY_STATUS] = (state_q == AST_IDLE);
                rd_byte[`AST_B_TRANSMIT_NINTH_BIT] = cfg_q.transmit_ninth_bit;
            end
            `AST_OFF_RSC: rd_byte[`AST_B_SERIAL_PORT_ENABLE] = serial_port_enable_q;
            `AST_OFF_TBUF: rd_byte = tbuf_q;
            `AST_OFF_BAUD: rd_byte = baud_q;
            `AST_OFF_FLAGS: rd_byte[`AST_B_BUFFER_EMPTY_FLAG] = flag_q;
            `AST_OFF_ENAB: rd_byte = enab_q;
            default: mapped = 1'b0;
        endcase
    end

    // answer one cycle after setup
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pready_out <= 1'b0;
            prdata_out <= 32'h0000_0000;
            pslverr_out <= 1'b0;
        end else begin
            pready_out <= setup;
            if (setup) begin
                prdata_out <= {24'h00_0000, rd_byte};
                pslverr_out <= !mapped;
            end
        end
    end

    // software registers
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cfg_q <= '0;
            serial_port_enable_q <= 1'b0;
            baud_q <= `AST_RST_REG;
            enab_q <= `AST_RST_REG;
        end else if (wr_en) begin
            case (paddr_in)
                `AST_OFF_TSC: begin
                    cfg_q.tx9 <= pwdata_in[`AST_B_TX9];
                    cfg_q.transmit_enable_bit <= pwdata_in[`AST_B_TRANSMIT_ENABLE_BIT];
                    cfg_q.sync <= pwdata_in[`AST_B_SYNC];
                    cfg_q.high_speed_select <= pwdata_in[`AST_B_HIGH_SPEED_SELECT];
                    cfg_q.transmit_ninth_bit <= pwdata_in[`AST_B_TRANSMIT_NINTH_BIT];
                end
                `AST_OFF_RSC: serial_port_enable_q <= pwdata_in[`AST_B_SERIAL_PORT_ENABLE];
                `AST_OFF_BAUD: baud_q <= pwdata_in[7:0];
                `AST_OFF_ENAB: enab_q <= pwdata_in[7:0];
                default: ;
            endcase
        end
    end

    assign transmit_enable_bit_rise = wr_en && (paddr_in == `AST_OFF_TSC) &&
        pwdata_in[`AST_B_TRANSMIT_ENABLE_BIT] && !cfg_q.transmit_enable_bit;

    // port runs only when enabled, asynchronous and awake
    assign run = serial_port_enable_q && cfg_q.transmit_enable_bit && !cfg_q.sync && !sleep_in;
    assign xfer = run && (state_q == AST_IDLE) && tbuf_full_q;

    // transmit buffer
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tbuf_q <= `AST_RST_REG;
            tbuf_full_q <= 1'b0;
        end else begin
            if (wr_tbuf) begin
                tbuf_q <= pwdata_in[7:0];
                tbuf_full_q <= 1'b1;
            end else if (xfer) begin
                tbuf_full_q <= 1'b0;
            end
        end
    end

    // buffer-empty flag; software writes to it are ignored
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            flag_q <= 1'b0;
        end else if (wr_tbuf) begin
            flag_q <= 1'b0;
        end else if (xfer || transmit_enable_bit_rise) begin
            flag_q <= 1'b1;
        end
    end

    // request gated by enable, flag itself unaffected
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tx_irq_out <= 1'b0;
        end else begin
            tx_irq_out <= flag_q && enab_q[`AST_B_BUFFER_EMPTY_FLAG];
        end
    end

    // baud generator, restarted while the shifter idles
    assign bit_tick = run && (brg_cnt_q == 8'h00) &&
        (os_cnt_q == 6'h00);

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            brg_cnt_q <= 8'h00;
            os_cnt_q <= 6'h00;
        end else if (state_q == AST_IDLE || state_q == AST_LOAD) begin
            brg_cnt_q <= baud_q;
            os_cnt_q <= cfg_q.high_speed_select ? `AST_OS_HI : `AST_OS_LO;
        end else if (run) begin
            if (brg_cnt_q == 8'h00) begin
                brg_cnt_q <= baud_q;
                if (os_cnt_q == 6'h00) begin
                    os_cnt_q <= cfg_q.high_speed_select ? `AST_OS_HI : `AST_OS_LO;
                end else begin
                    os_cnt_q <= os_cnt_q - 6'h01;
                end
            end else begin
                brg_cnt_q <= brg_cnt_q - 8'h01;
            end
        end
    end

    // frame sequencer; frozen in sleep unless the serial port enable is cleared
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_q <= AST_IDLE;
            shift_q <= 9'h1FF;
            bit_cnt_q <= 4'h0;
            tx_out <= 1'b1;
        end else if (!serial_port_enable_q) begin
            state_q <= AST_IDLE;
            tx_out <= 1'b1;
        end else if (!sleep_in) begin
            case (state_q)
                AST_IDLE: begin
                    tx_out <= 1'b1;
                    if (xfer) begin
                        shift_q <= {cfg_q.transmit_ninth_bit, tbuf_q};
                        state_q <= AST_LOAD;
                    end
                end
                AST_LOAD: begin
                    tx_out <= 1'b0;
                    bit_cnt_q <= cfg_q.tx9 ? `AST_NB9 : `AST_NB8;
                    state_q <= AST_START;
                end
                AST_START: begin
                    if (bit_tick) begin
                        tx_out <= shift_q[0];
                        shift_q <= {1'b1, shift_q[8:1]};
                        state_q <= AST_DATA;
                    end
                end
                AST_DATA: begin
                    if (bit_tick) begin
                        if (bit_cnt_q == 4'h0) begin
                            tx_out <= 1'b1;
                            state_q <= AST_STOP;
                        end else begin
                            tx_out <= shift_q[0];
                            shift_q <= {1'b1, shift_q[8:1]};
                            bit_cnt_q <= bit_cnt_q - 4'h1;
                        end
                    end
                end
                AST_STOP: begin
                    if (bit_tick) begin
                        state_q <= AST_IDLE;
                    end
                end
                default: state_q <= AST_IDLE;
            endcase
        end
    end

    // checks
    // helper: cycles since the last bit tick, for period checks
    logic [15:0] gap_q;
    logic steady_q;
    logic in_frame;
    logic [5:0] os_max;
    logic [15:0] period_m1;

    assign in_frame = (state_q == AST_START) || (state_q == AST_DATA) ||
        (state_q == AST_STOP);
    assign os_max = cfg_q.high_speed_select ? `AST_OS_HI : `AST_OS_LO;
    assign period_m1 = ({8'h00, baud_q} + 16'h0001) *
        ({10'h000, os_max} + 16'h0001) - 16'h0001;

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            gap_q <= 16'h0000;
        end else if (state_q == AST_LOAD || bit_tick) begin
            gap_q <= 16'h0000;
        end else if (run && in_frame) begin
            gap_q <= gap_q + 16'h0001;
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            steady_q <= 1'b0;
        end else if (wr_en && (paddr_in == `AST_OFF_BAUD ||
                paddr_in == `AST_OFF_TSC)) begin
            steady_q <= 1'b0;
        end else if (state_q == AST_LOAD) begin
            steady_q <= 1'b1;
        end
    end

    sequence load_s;
        state_q == AST_IDLE && xfer;
    endsequence

    sequence start_s;
        state_q == AST_LOAD ##1 !tx_out;
    endsequence

    xfer_flag_a: assert property (
        @(posedge core_clk_in) disable iff (!resetn_in)
        xfer && !wr_tbuf |=> flag_q && !tbuf_full_q)
        else $error("flag not set after transfer");

    load_start_a: assert property (
        @(posedge core_clk_in) disable iff (!resetn_in)
        load_s ##1 (!sleep_in && serial_port_enable_q) |-> start_s)
        else $error("start bit missing after load");

    flag_clear_a: assert property (
        @(posedge core_clk_in) disable iff (!resetn_in)
        flag_q && !wr_tbuf |=> flag_q)
        else $error("flag cleared without buffer write");

    transmit_enable_bit_flag_a: assert property (
        @(posedge core_clk_in) disable iff (!resetn_in)
        transmit_enable_bit_rise && !wr_tbuf |=> flag_q)
        else $error("enable did not set flag");

    irq_gate_a: assert property (
        @(posedge core_clk_in) disable iff (!resetn_in)
        tx_irq_out == ($past(flag_q) && $past(enab_q[`AST_B_BUFFER_EMPTY_FLAG])))
        else $error("request not gated by enable");

    no_reload_a: assert property (
        @(posedge core_clk_in) disable iff (!resetn_in)
        state_q == AST_STOP && !bit_tick && serial_port_enable_q |=> state_q == AST_STOP)
        else $error("reload before stop bit");

    sleep_hold_a: assert property (
        @(posedge core_clk_in) disable iff (!resetn_in)
        sleep_in && $past(sleep_in) && $past(serial_port_enable_q) |->
        $stable(state_q) && !bit_tick)
        else $error("activity during sleep");

    stop_high_a: assert property (
        @(posedge core_clk_in) disable iff (!resetn_in)
        state_q == AST_STOP || state_q == AST_IDLE |-> tx_out)
        else $error("line not high at stop or idle");

    sync_block_a: assert property (
        @(posedge core_clk_in) disable iff (!resetn_in)
        cfg_q.sync && state_q == AST_IDLE |=> state_q == AST_IDLE)
        else $error("frame started in clocked mode");

    tick_period_a: assert property (
        @(posedge core_clk_in) disable iff (!resetn_in)
        bit_tick && steady_q |-> gap_q == period_m1)
        else $error("bit tick spacing wrong");

    tick_late_a: assert property (
        @(posedge core_clk_in) disable iff (!resetn_in)
        steady_q && in_frame |-> gap_q <= period_m1)
        else $error("bit tick overdue");

    lsb_first_a: assert property (
        @(posedge core_clk_in) disable iff (!resetn_in)
        state_q == AST_START && bit_tick |=> tx_out == $past(shift_q[0]))
        else $error("first data bit is not bit zero");

    ninth_bit_a: assert property (
        @(posedge core_clk_in) disable iff (!resetn_in)
        xfer |=> state_q == AST_LOAD && shift_q[8] == $past(cfg_q.transmit_ninth_bit)
        && shift_q[7:0] == $past(tbuf_q))
        else $error("shift register load wrong");

    stop_bits_a: assert property (
        @(posedge core_clk_in) disable iff (!resetn_in)
        state_q == AST_DATA && bit_tick && bit_cnt_q == 4'h0 |=>
        state_q == AST_STOP && tx_out)
        else $error("stop bit not sent after last data bit");

    pready_pulse_a: assert property (
        @(posedge core_clk_in) disable iff (!resetn_in)
        pready_out |=> !pready_out)
        else $error("ready held longer than one cycle");

    abort_idle_a: assert property (
        @(posedge core_clk_in) disable iff (!resetn_in)
        !serial_port_enable_q |=> state_q == AST_IDLE && tx_out)
        else $error("disabled port left the line low");
endmodule
